// >>> prs_pkg.sv
// Purpose: constants and types for the panel reset threshold/delay bank
// Assumes: AHB-Lite slave on a 25 MHz hclk, one word per register
// Notes: register index times four gives the byte address
package prs_pkg;
    localparam int ADDR_W = 12;
    localparam int INDEX_W = ADDR_W - 2;
    localparam logic [INDEX_W-1:0] THRESH_INDEX = 10'h011;
    localparam logic [INDEX_W-1:0] DELAY_INDEX = 10'h012;
    localparam int FIELD_LSB = 0;
    localparam int FIELD_W = 4;
    localparam logic [FIELD_W-1:0] THRESH_RESET = 4'h0;
    localparam logic [FIELD_W-1:0] DELAY_RESET = 4'h0;
    // threshold decode
    localparam logic [FIELD_W-1:0] THRESH_LOCKOUT_CODE = 4'h0;
    localparam logic [FIELD_W-1:0] THRESH_MAX_CODE = 4'hB;
    localparam int THRESH_BASE_MV = 2000;
    localparam int THRESH_STEP_MV = 100;
    localparam int LEVEL_W = 12;
    // delay decode and timebase
    localparam logic [FIELD_W-1:0] DELAY_MAX_CODE = 4'h7;
    localparam int DELAY_STEP_MS = 5;
    localparam int DELAY_MS_W = 6;
    localparam int CLK_HZ = 25_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES_DEFAULT = CLK_HZ / MS_PER_S;

    // settings handed to the analog threshold comparator
    typedef struct packed {
        logic undervoltage_lockout_level_select;
        logic [LEVEL_W-1:0] level_mv;
    } prs_thresh_t;
endpackage

// >>> prs_delay_timer.sv
// Purpose: holds the panel reset low until the start delay has run out
// Assumes: supply_ok already synchronised to clk
// Notes: the delay value is sampled live while counting
`timescale 1ns/1ps
`default_nettype none
module prs_delay_timer #(
    parameter int MS_CYCLES = 25000,
    parameter int MS_W = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supply_ok,
    input wire logic [MS_W-1:0] delay_ms,
    output logic released
);
    localparam int PW = $clog2(MS_CYCLES + 1);

    typedef enum logic [1:0] {ST_HOLD, ST_COUNT, ST_OPEN} prs_tstate_t;

    prs_tstate_t state;
    prs_tstate_t next_state;
    logic [PW-1:0] presc;
    logic [PW-1:0] next_presc;
    logic [MS_W-1:0] ms_cnt;
    logic [MS_W-1:0] next_ms_cnt;

    generate
        if (MS_CYCLES < 1 || MS_W < 1) begin : g_bad
            $error("prs_delay_timer: MS_CYCLES and MS_W must be positive");
        end
    endgenerate

    wire ms_tick = (presc == PW'(MS_CYCLES - 1));
    wire delay_done = (ms_cnt >= delay_ms);

    // sequencing; a supply drop always forces the reset back on
    always_comb begin
        next_state = state;
        next_presc = presc;
        next_ms_cnt = ms_cnt;
        case (state)
            ST_HOLD: begin
                next_presc = '0;
                next_ms_cnt = '0;
                if (supply_ok) begin
                    next_state = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (!supply_ok) begin
                    next_state = ST_HOLD;
                end else if (delay_done) begin
                    next_state = ST_OPEN;
                end else if (ms_tick) begin
                    next_presc = '0;
                    next_ms_cnt = ms_cnt + 1'b1;
                end else begin
                    next_presc = presc + 1'b1;
                end
            end
            ST_OPEN: begin
                if (!supply_ok) begin
                    next_state = ST_HOLD;
                end
            end
            default: begin
                next_state = ST_HOLD;
            end
        endcase
    end

    // state and the released level, both from flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_HOLD;
            presc <= '0;
            ms_cnt <= '0;
            released <= 1'b0;
        end else begin
            state <= next_state;
            presc <= next_presc;
            ms_cnt <= next_ms_cnt;
            released <= (next_state == ST_OPEN);
        end
    end

    // checking helper: cycles since supply came good, saturating
    int elapsed;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            elapsed <= 0;
        end else if (!supply_ok) begin
            elapsed <= 0;
        end else if (elapsed < 32'h7FFF_FFFF) begin
            elapsed <= elapsed + 1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence supply_rise_s;
        $rose(supply_ok) && (delay_ms == '0);
    endsequence
    sequence steady_supply_s;
        supply_ok [*3];
    endsequence

    no_early_release_a: assert property (
        $rose(released) |-> (elapsed >= int'(delay_ms) * MS_CYCLES))
        else $error("reset released before the start delay ran out");
    zero_delay_open_a: assert property (
        supply_rise_s ##0 steady_supply_s |-> ##0 released)
        else $error("zero delay did not release the reset in time");
    drop_holds_a: assert property (
        !supply_ok |=> !released)
        else $error("reset stayed released after supply drop");
endmodule
`default_nettype wire

// >>> prs_regs.sv
// Purpose: threshold and start delay registers for the panel reset output
// Assumes: AHB-Lite single word transfers, zero wait states, OKAY only
// Notes: supply_ok_pin is asynchronous and is synchronised here
// Notes: the panel reset is released only while the supply holds good
`timescale 1ns/1ps
`default_nettype none
module prs_regs #(
    parameter int MS_CYCLES = prs_pkg::MS_CYCLES_DEFAULT
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [prs_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic supply_ok_pin,
    output prs_pkg::prs_thresh_t threshold_cfg,
    output logic [prs_pkg::FIELD_W-1:0] threshold_code,
    output logic panel_reset_out_n
);
    import prs_pkg::*;

    logic [FIELD_W-1:0] delay_code;
    logic wr_pend;
    logic [INDEX_W-1:0] wr_index;
    logic supply_meta;
    logic supply_sync;
    logic [DELAY_MS_W-1:0] delay_ms;

    // the longest step must fit the delay width handed to the timer
    generate
        if (MS_CYCLES < 1 || DELAY_STEP_MS * int'(DELAY_MAX_CODE) >=
                2 ** DELAY_MS_W) begin : g_bad
            $error("prs_regs: MS_CYCLES or delay width out of range");
        end
    endgenerate

    // readback of one register; upper bits always zero
    function automatic logic [31:0] reg_read(
        input logic [INDEX_W-1:0] idx,
        input logic [FIELD_W-1:0] thr,
        input logic [FIELD_W-1:0] dly
    );
        logic [31:0] val;
        val = 32'h0000_0000;
        if (idx == THRESH_INDEX) begin
            val[FIELD_LSB +: FIELD_W] = thr;
        end else if (idx == DELAY_INDEX) begin
            val[FIELD_LSB +: FIELD_W] = dly;
        end
        return val;
    endfunction

    // address phase decode; hsize is not checked, only words are used
    wire addr_ok = hsel & htrans[1] & hready;
    wire [INDEX_W-1:0] addr_index = haddr[ADDR_W-1:2];
    wire rd_take = addr_ok & ~hwrite;
    wire wr_thresh = wr_pend & (wr_index == THRESH_INDEX);
    wire wr_delay = wr_pend & (wr_index == DELAY_INDEX);

    // only the low field is stored; upper write data falls away
    wire [FIELD_W-1:0] wr_field = hwdata[FIELD_LSB +: FIELD_W];
    wire [FIELD_W-1:0] next_threshold_code =
        wr_thresh ? wr_field : threshold_code;
    wire [FIELD_W-1:0] next_delay_code =
        wr_delay ? wr_field : delay_code;

    // read data uses next values so a read right after a write sees it
    wire [31:0] next_hrdata = rd_take ?
        reg_read(addr_index, next_threshold_code, next_delay_code) :
        32'h0000_0000;

    // zero wait states: never stalls, never errors
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // bus phase tracking and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_index <= '0;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend <= addr_ok & hwrite;
            wr_index <= addr_index;
            hrdata <= next_hrdata;
        end
    end

    // configuration storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            threshold_code <= THRESH_RESET;
            delay_code <= DELAY_RESET;
        end else begin
            threshold_code <= next_threshold_code;
            delay_code <= next_delay_code;
        end
    end

    // codes above B clamp to the 3.0 V step; code 0 picks lockout
    wire [FIELD_W-1:0] thresh_eff = (threshold_code > THRESH_MAX_CODE) ?
        THRESH_MAX_CODE : threshold_code;
    wire thresh_lockout = (threshold_code == THRESH_LOCKOUT_CODE);
    wire [LEVEL_W-1:0] thresh_mv = thresh_lockout ? '0 :
        LEVEL_W'(THRESH_BASE_MV +
        (int'(thresh_eff) - 1) * THRESH_STEP_MV);

    // comparator settings leave through flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            threshold_cfg <= '0;
        end else begin
            threshold_cfg.undervoltage_lockout_level_select <= thresh_lockout;
            threshold_cfg.level_mv <= thresh_mv;
        end
    end

    // undocumented delay codes are held at the longest step
    wire [FIELD_W-1:0] delay_eff = (delay_code > DELAY_MAX_CODE) ?
        DELAY_MAX_CODE : delay_code;
    assign delay_ms = DELAY_MS_W'(int'(delay_eff) * DELAY_STEP_MS);

    // supply detect pin crosses in through two flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            supply_meta <= 1'b0;
            supply_sync <= 1'b0;
        end else begin
            supply_meta <= supply_ok_pin;
            supply_sync <= supply_meta;
        end
    end

    // panel reset stays low until the delay has elapsed
    prs_delay_timer #(
        .MS_CYCLES(MS_CYCLES),
        .MS_W(DELAY_MS_W)
    ) u_timer (
        .clk(hclk),
        .rst_n(hresetn),
        .supply_ok(supply_sync),
        .delay_ms(delay_ms),
        .released(panel_reset_out_n)
    );

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence thresh_write_s;
        addr_ok && hwrite && (addr_index == THRESH_INDEX);
    endsequence
    sequence delay_write_s;
        addr_ok && hwrite && (addr_index == DELAY_INDEX);
    endsequence

    thresh_write_a: assert property (
        thresh_write_s ##1 1'b1 |=>
        threshold_code == $past(hwdata[FIELD_W-1:0]))
        else $error("threshold write not stored");
    delay_write_a: assert property (
        delay_write_s ##1 1'b1 |=>
        delay_code == $past(hwdata[FIELD_W-1:0]))
        else $error("delay write not stored");
    thresh_read_a: assert property (
        rd_take && (addr_index == THRESH_INDEX) |=>
        hrdata[FIELD_W-1:0] == threshold_code)
        else $error("threshold readback wrong");
    delay_read_a: assert property (
        rd_take && (addr_index == DELAY_INDEX) |=>
        hrdata[FIELD_W-1:0] == delay_code)
        else $error("delay readback wrong");
    upper_zero_a: assert property (
        hrdata[31:FIELD_W] == '0)
        else $error("unimplemented bits read nonzero");
    lockout_map_a: assert property (
        threshold_code == 4'h0 |=> threshold_cfg.undervoltage_lockout_level_select)
        else $error("code 0 did not select lockout level");
    clamp_map_a: assert property (
        threshold_code >= 4'hB |=>
        threshold_cfg.level_mv == 12'hBB8 && !threshold_cfg.undervoltage_lockout_level_select)
        else $error("high threshold codes not at 3.0 V");
    step_map_a: assert property (
        threshold_code == 4'h1 |=> threshold_cfg.level_mv == 12'h7D0)
        else $error("code 1 not at 2.0 V");
    delay_clamp_a: assert property (
        delay_code > 4'h7 |-> delay_ms == 6'h23)
        else $error("undocumented delay code not at 35 ms");

    // stored fields move only on a write to their own index
    thresh_hold_a: assert property (
        !wr_thresh |=> $stable(threshold_code))
        else $error("threshold field changed without a write");
    delay_hold_a: assert property (
        !wr_delay |=> $stable(delay_code))
        else $error("delay field changed without a write");
    // read data stays quiet outside a read and for unmapped reads
    idle_rdata_a: assert property (
        !rd_take |=> hrdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (
        rd_take && (addr_index != THRESH_INDEX) &&
        (addr_index != DELAY_INDEX) |=> hrdata == 32'h0000_0000)
        else $error("unmapped index read nonzero");
    // every documented threshold step lands 100 mV apart
    level_step_a: assert property (
        threshold_code inside {[4'h1:4'hB]} |=>
        threshold_cfg.level_mv == 12'h7D0 +
        12'h064 * LEVEL_W'($past(threshold_code) - 4'h1))
        else $error("threshold step level wrong");
    lockout_only_zero_a: assert property (
        threshold_code != 4'h0 |=> !threshold_cfg.undervoltage_lockout_level_select)
        else $error("lockout level picked by a nonzero code");
    delay_map_a: assert property (
        delay_code <= DELAY_MAX_CODE |->
        delay_ms == DELAY_MS_W'(delay_code) * 6'h05)
        else $error("documented delay code mapped wrong");
    // a low supply reaches the panel reset two edges after the first flop
    pin_drop_a: assert property (
        !supply_meta |=> ##1 !panel_reset_out_n)
        else $error("panel reset not asserted after supply drop");
endmodule
`default_nettype wire

// >>> prs_host_model.sv
// Purpose: bus master standing in for the host that programs the bank
// Assumes: single slave, hready fed back from its hreadyout
// Notes: waits are unbounded here; the bench timeout cuts a hang
`timescale 1ns/1ps
`default_nettype none
module prs_host_model (
    input wire logic hclk,
    output logic hsel,
    output logic [prs_pkg::ADDR_W-1:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    import prs_pkg::*;
    // idle bus at time zero, data line driven to zero
    initial begin
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // one single word transfer: address phase, then data phase
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        hsel <= 1'b0;
        hwdata <= ~d; // released: never leave the last value standing
    endtask
endmodule
`default_nettype wire

// >>> prs_regs_tb.sv
// Purpose: self-checking bench for the panel reset register bank
// Assumes: MS_CYCLES shortened to 4 so delays stay short
// Notes: delays are checked relative to the code 0 response time
`timescale 1ns/1ps
`default_nettype none
module prs_regs_tb;
    import prs_pkg::*;
    localparam int MSC = 4;
    logic hclk, hresetn, hsel, hwrite, hready, hresp, pin, rst_out_n;
    logic [ADDR_W-1:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, q;
    logic [FIELD_W-1:0] thr_code;
    prs_thresh_t thr_cfg, te;
    int fails, checks_done, cyc, base, n;

    prs_regs #(.MS_CYCLES(MSC)) dut_u (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .supply_ok_pin(pin), .threshold_cfg(thr_cfg),
        .threshold_code(thr_code), .panel_reset_out_n(rst_out_n));
    prs_host_model host_u (.hclk(hclk), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // hang guard, well above the longest delay sweep
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            fails = fails + 1;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        host_u.xfer(1'b0, a, 32'h0, q);
        check(q, e);
        check({31'h0, hresp}, 32'h0);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, q);
    endtask
    // cycles from supply good to panel reset release, then drop again
    task automatic release_time(output int t);
        t = 0;
        @(posedge hclk);
        pin <= 1'b1;
        do begin
            @(posedge hclk);
            t = t + 1;
        end while (rst_out_n !== 1'b1 && t < 400);
        pin <= 1'b0;
        repeat (4) @(posedge hclk);
        #1 check({31'h0, rst_out_n}, 32'h0);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        fails = 0;
        checks_done = 0;
        cyc = 0;
        hresetn = 1'b0;
        pin = 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        // reset contents, then upper bits dropped, unmapped write and read
        rd(12'h044, 32'h0);
        rd(12'h048, 32'h0);
        wr(12'h044, 32'hFFFF_FFA5);
        wr(12'h048, 32'h1234_56F3);
        wr(12'h040, 32'hFFFF_FFFF);
        rd(12'h044, 32'h5);
        rd(12'h048, 32'h3);
        rd(12'h040, 32'h0); // unmapped
        $display("test regs done");
        // every threshold code and its decoded level
        for (int c = 0; c < 16; c++) begin
            wr(12'h044, 32'hA0 | c);
            repeat (3) @(posedge hclk);
            te.undervoltage_lockout_level_select = (c == 0);
            n = (c > 11) ? 11 : c;
            te.level_mv = (c == 0) ? 12'h0 :
                LEVEL_W'(THRESH_BASE_MV + (n - 1) * THRESH_STEP_MV);
            #1 check({28'h0, thr_code}, c);
            check({19'h0, thr_cfg}, {19'h0, te});
            rd(12'h044, c);
        end
        $display("test threshold done");
        // delay codes against code 0, including the undocumented ones
        wr(12'h048, 32'h0);
        release_time(base);
        for (int c = 1; c < 16; c += 2) begin
            wr(12'h048, 32'hF0 | c);
            rd(12'h048, c);
            release_time(n);
            n = n - base;
            check(n, ((c > 7) ? 7 : c) * DELAY_STEP_MS * MSC);
        end
        $display("test delay done");
        finish_test();
    end
endmodule
`default_nettype wire
